// ---- ppsp_asserts.sv ----
// bus timing and pin checker for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module ppsp_chk (
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins
  input wire logic        write_strobe_pin_oe_n_o,
  input wire logic        read_strobe_pin_oe_n_o,
  input wire logic        irq_o
);
  // ==========================================
  // one clock domain, reset masks everything
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_latency_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_idle_a:
    assert property (!wb_cyc_i |=> !wb_ack_o) else $error("ack without request");
  rdata_hold_a:
    assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i) else $error("read data moved");
  unmapped_zero_a:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
  // both strobe pins are driven together in master modes
  oe_pair_a:
    assert property (write_strobe_pin_oe_n_o == read_strobe_pin_oe_n_o) else $error("enables differ");
  oe_fall_a:
    assert property ($fell(write_strobe_pin_oe_n_o)
      |-> $past(wb_ack_o && wb_we_i && (wb_adr_i == 8'h04 || wb_adr_i == 8'h0c)))
      else $error("pins driven without mode write");
  oe_rise_a:
    assert property ($rose(write_strobe_pin_oe_n_o)
      |-> $past(wb_ack_o && wb_we_i && (wb_adr_i == 8'h04 || wb_adr_i == 8'h0c)))
      else $error("pins released without mode write");
  irq_fall_a:
    assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i)) else $error("irq dropped by itself");
endmodule
bind ppsp_top ppsp_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .write_strobe_pin_oe_n_o(write_strobe_pin_oe_n_o), .read_strobe_pin_oe_n_o(read_strobe_pin_oe_n_o),
  .irq_o(irq_o));
`default_nettype wire

// ---- ppsp_defs.vh ----
// register offsets, field positions, reset values and timing counts of the parallel port block
`ifndef PPSP_DEFS_VH
`define PPSP_DEFS_VH
// ==================================================
// register byte offsets
`define PPSP_OFF_CONTROL   8'h00
`define PPSP_OFF_MODE      8'h04
`define PPSP_OFF_XFER      8'h08
`define PPSP_OFF_PINFUNC   8'h0c
`define PPSP_OFF_IRQ_STAT  8'h10
`define PPSP_OFF_IRQ_MASK  8'h14
// ==================================================
// port control fields
`define PPSP_BIT_BYTE_EN_POL  2
`define PPSP_BIT_WR_POL       1
`define PPSP_BIT_RD_POL       0
// ==================================================
// port mode fields
`define PPSP_BIT_BUSY      15
`define PPSP_REQ_MODE_HI   14
`define PPSP_REQ_MODE_LO   13
`define PPSP_MODE_HI       9
`define PPSP_MODE_LO       8
`define PPSP_MODE_LEGACY   2'h0
`define PPSP_MODE_ENHANCED 2'h1
`define PPSP_MODE_MASTER2  2'h2
`define PPSP_MODE_MASTER1  2'h3
`define PPSP_REQ_NONE      2'h0
`define PPSP_REQ_CYCLE     2'h1
`define PPSP_REQ_BUF3      2'h3
// ==================================================
// transfer register fields
`define PPSP_BIT_XFER_GO   0
`define PPSP_BIT_XFER_WR   1
`define PPSP_ADDR_HI       10
`define PPSP_ADDR_LO       8
// ==================================================
// interrupt status bits
`define PPSP_IRQ_DONE      0
`define PPSP_IRQ_CYCLE     1
`define PPSP_IRQ_BUF3      2
// ==================================================
// reset values
`define PPSP_RST_CONTROL   16'h0000
`define PPSP_RST_MODE      16'h0000
// writable part of the mode register, busy bit excluded
`define PPSP_RST_MODE_RW   15'h0000
`define PPSP_RST_PINFUNC   3'h0
`define PPSP_RST_IRQ       3'h0
// ==================================================
// master transfer timing, in clock cycles
`define PPSP_SETUP_CYC     4'h1
`define PPSP_STROBE_CYC    4'h2
`define PPSP_HOLD_CYC      4'h1
`define PPSP_LAST_BUF      2'h3
`endif

// ---- ppsp_host_model.sv ----
// external host that runs slave cycles against the port
`timescale 1ns/1ps
`default_nettype none
module ppsp_host_model (
  // clock
  input wire logic  clk_i,
  // towards the port
  output logic       cs_o,
  output logic [1:0] adr_o,
  output logic       wr_o,
  output logic       rd_o
);
  logic wpol;
  logic rpol;
  // idle: deselected, strobes at the low-active idle level
  initial begin
    {cs_o, adr_o, wr_o, rd_o, wpol, rpol} = 7'b0001100;
  end
  task automatic set_pol(input logic w, input logic r);
    @(posedge clk_i);
    {wpol, rpol, wr_o, rd_o} <= {w, r, !w, !r};
  endtask
  // one strobe of two cycles at buffer i
  task automatic cycle(input logic w, input logic [1:0] i);
    @(posedge clk_i);
    {cs_o, adr_o} <= {1'b1, i};
    @(posedge clk_i);
    if (w) wr_o <= wpol;
    else rd_o <= rpol;
    repeat (2) @(posedge clk_i);
    {wr_o, rd_o} <= {!wpol, !rpol};
    repeat (2) @(posedge clk_i);
    // released lines show the inverse, never the old index
    {cs_o, adr_o} <= {1'b0, ~i};
  endtask
endmodule
`default_nettype wire

// ---- ppsp_pol.v ----
// per-pin polarity and address-line selection for the three control pins
`timescale 1ns/1ps
`default_nettype none
module ppsp_pol (
  // logical strobe activity and settings
  input  wire [2:0] act_i,
  input  wire [2:0] pol_i,
  input  wire [2:0] addr_sel_i,
  input  wire [2:0] addr_i,
  // pin levels
  output wire [2:0] pin_o
);
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin
      // polarity bit is ignored while the pin carries an address bit
      assign pin_o[g] = addr_sel_i[g] ? addr_i[g] : (act_i[g] ~^ pol_i[g]);
    end
  endgenerate
endmodule
`default_nettype wire

// ---- ppsp_top.v ----
// parallel port strobe polarity, mode, busy and interrupt block with wishbone registers
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ppsp_defs.vh"
module ppsp_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // port pins
  input  wire        chip_select_one_pin_i,
  input  wire [1:0]  port_address_lines_i,
  output wire        byte_enable_pin_o,
  input  wire        write_strobe_pin_i,
  output wire        write_strobe_pin_o,
  output wire        write_strobe_pin_oe_n_o,
  input  wire        read_strobe_pin_i,
  output wire        read_strobe_pin_o,
  output wire        read_strobe_pin_oe_n_o,
  // interrupt
  output wire        irq_o
);
  // ==================================================
  // registers
  reg  [15:0] port_control_q;
  reg  [14:0] port_mode_q;
  reg         xfer_wr_q;
  reg  [2:0]  xfer_addr_q;
  reg  [2:0]  pin_func_q;
  reg  [2:0]  irq_stat_q;
  reg  [2:0]  irq_stat_d;
  reg  [2:0]  irq_mask_q;
  reg  [31:0] rdata_d;
  reg         rd_act_q;
  reg         wr_act_q;
  reg  [1:0]  buf_idx_q;
  reg         hit_ctrl;
  reg         hit_mode;
  reg         hit_xfer;
  reg         hit_pinf;
  reg         hit_stat;
  reg         hit_mask;

  wire        req;
  wire        wr_take;
  wire        rd_load;
  wire        busy;
  wire        strobe;
  wire        done;
  wire        start;
  wire [1:0]  mode;
  wire [1:0]  req_mode;
  wire        is_master;
  wire        is_master1;
  wire        rd_act;
  wire        wr_act;
  wire        rd_event;
  wire        wr_event;
  wire        cycle_event;
  wire        buf3_event;
  wire [1:0]  buf_idx;
  wire [15:0] mode_rd;
  wire [2:0]  pin_act;
  wire [2:0]  pin_pol;
  wire [2:0]  pin_lvl;

  // ==================================================
  // wishbone handshake
  // one wait cycle: ack rises one edge after the request, and
  // the write lands on the edge where the master sees ack
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_take = req & wb_ack_o & wb_we_i;
  assign rd_load = req & ~wb_ack_o & ~wb_we_i; // read data holds across writes

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (rd_load) begin
        wb_dat_o <= rdata_d;
      end
    end
  end

  // ==================================================
  // mode decode
  // mode field selection
  assign mode       = port_mode_q[`PPSP_MODE_HI:`PPSP_MODE_LO];
  assign req_mode   = port_mode_q[`PPSP_REQ_MODE_HI:`PPSP_REQ_MODE_LO];
  assign is_master  = (mode == `PPSP_MODE_MASTER1) | (mode == `PPSP_MODE_MASTER2);
  assign is_master1 = (mode == `PPSP_MODE_MASTER1);

  // busy flag read-only in bit 15
  assign mode_rd = {busy & is_master, port_mode_q};

  // ==================================================
  // operating notes
  // bus: one wait cycle, ack is a one-cycle pulse
  // writes land on the edge that sees ack high
  // read data loads only for reads, holds across writes
  // unmapped offsets ack, read zero, drop writes
  // byte lanes 3 and 2 ignored, all fields sit low
  // mode bit 15 is busy and ignores writes
  // transfer: 1 setup, 2 strobe, 1 hold cycle
  // wait-state fields not modelled, timing is fixed
  // a go while busy or in slave mode is dropped
  // direction and address freeze while busy
  // byte enable spans all four busy cycles
  // mode 1: read pin gives direction, write pin enables
  // mode 2: read and write pins strobe separately
  // slave: a cycle ends when its strobe is released
  // slave strobes count only with chip select high
  // enhanced slave takes the buffer from address lines
  // legacy slave steps its own counter, cleared in master
  // request mode 01 flags master done and slave cycles
  // request mode 10 raises nothing here
  // request mode 11 flags the last buffer only
  // status bits stick until a one is written back
  // inputs taken as already synchronous
  // pins combinational from flops, no glitch filter
  // data path and chip select drive live elsewhere

  // ==================================================
  // address decode, at most one hit; unmapped offsets hit nothing
  always @* begin
    hit_ctrl = 1'b0;
    hit_mode = 1'b0;
    hit_xfer = 1'b0;
    hit_pinf = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    if (wb_adr_i == `PPSP_OFF_CONTROL) begin
      hit_ctrl = 1'b1;
    end else if (wb_adr_i == `PPSP_OFF_MODE) begin
      hit_mode = 1'b1;
    end else if (wb_adr_i == `PPSP_OFF_XFER) begin
      hit_xfer = 1'b1;
    end else if (wb_adr_i == `PPSP_OFF_PINFUNC) begin
      hit_pinf = 1'b1;
    end else if (wb_adr_i == `PPSP_OFF_IRQ_STAT) begin
      hit_stat = 1'b1;
    end else if (wb_adr_i == `PPSP_OFF_IRQ_MASK) begin
      hit_mask = 1'b1;
    end
  end

  // ==================================================
  // read data mux, unmapped offsets read zero
  always @* begin
    rdata_d = 32'h00000000;
    if (hit_ctrl) begin
      rdata_d = {16'h0000, port_control_q};
    end else if (hit_mode) begin
      rdata_d = {16'h0000, mode_rd};
    end else if (hit_xfer) begin
      rdata_d = {21'h000000, xfer_addr_q, 6'h00, xfer_wr_q, busy};
    end else if (hit_pinf) begin
      rdata_d = {29'h00000000, pin_func_q};
    end else if (hit_stat) begin
      rdata_d = {29'h00000000, irq_stat_q};
    end else if (hit_mask) begin
      rdata_d = {29'h00000000, irq_mask_q};
    end
  end

  // ==================================================
  // register writes with byte lanes
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_control_q <= `PPSP_RST_CONTROL;
      port_mode_q    <= `PPSP_RST_MODE_RW;
      xfer_wr_q      <= 1'b0;
      xfer_addr_q    <= 3'h0;
      pin_func_q     <= `PPSP_RST_PINFUNC;
      irq_mask_q     <= `PPSP_RST_IRQ;
    end else if (wr_take) begin
      if (hit_ctrl) begin
        if (wb_sel_i[0]) begin
          port_control_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          port_control_q[15:8] <= wb_dat_i[15:8];
        end
      end else if (hit_mode) begin
        if (wb_sel_i[0]) begin
          port_mode_q[7:0] <= wb_dat_i[7:0];
        end
        // busy bit 15 ignores writes
        if (wb_sel_i[1]) begin
          port_mode_q[14:8] <= wb_dat_i[14:8];
        end
      end else if (hit_xfer) begin
        // direction and address freeze while a transfer runs
        if (wb_sel_i[0] & ~busy) begin
          xfer_wr_q <= wb_dat_i[`PPSP_BIT_XFER_WR];
        end
        if (wb_sel_i[1] & ~busy) begin
          xfer_addr_q <= wb_dat_i[`PPSP_ADDR_HI:`PPSP_ADDR_LO];
        end
      end else if (hit_pinf) begin
        if (wb_sel_i[0]) begin
          pin_func_q <= wb_dat_i[2:0];
        end
      end else if (hit_mask) begin
        if (wb_sel_i[0]) begin
          irq_mask_q <= wb_dat_i[2:0];
        end
      end
    end
  end

  // ==================================================
  // master transfer engine
  // a start while busy or outside master modes is dropped
  assign start = wr_take & hit_xfer & wb_sel_i[0]
                 & wb_dat_i[`PPSP_BIT_XFER_GO] & is_master & ~busy;

  ppsp_xfer u_xfer (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .start_i  (start),
    .busy_o   (busy),
    .strobe_o (strobe),
    .done_o   (done)
  );

  // ==================================================
  // slave side strobe decoding
  // slave read and write strobe polarity
  assign rd_act = chip_select_one_pin_i
                  & (read_strobe_pin_i ~^ port_control_q[`PPSP_BIT_RD_POL]);
  assign wr_act = chip_select_one_pin_i
                  & (write_strobe_pin_i ~^ port_control_q[`PPSP_BIT_WR_POL]);

  // a cycle ends when its strobe is released
  assign rd_event    = ~is_master & rd_act_q & ~rd_act;
  assign wr_event    = ~is_master & wr_act_q & ~wr_act;
  assign cycle_event = rd_event | wr_event;

  // enhanced mode addresses the buffers, legacy auto-steps them
  assign buf_idx = (mode == `PPSP_MODE_ENHANCED) ? port_address_lines_i : buf_idx_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_act_q  <= 1'b0;
      wr_act_q  <= 1'b0;
      buf_idx_q <= 2'h0;
    end else begin
      rd_act_q <= rd_act & ~is_master;
      wr_act_q <= wr_act & ~is_master;
      if (is_master) begin
        buf_idx_q <= 2'h0;
      end else if (cycle_event) begin
        buf_idx_q <= buf_idx_q + 2'h1;
      end
    end
  end

  assign buf3_event = cycle_event & (req_mode == `PPSP_REQ_BUF3)
                      & (buf_idx == `PPSP_LAST_BUF);

  // ==================================================
  // sticky interrupt status, write one to clear
  // a set in the clearing cycle wins so no event is lost
  always @* begin
    irq_stat_d = irq_stat_q;
    if (wr_take & hit_stat & wb_sel_i[0]) begin
      irq_stat_d = irq_stat_q & ~wb_dat_i[2:0];
    end
    if (done & (req_mode == `PPSP_REQ_CYCLE)) begin
      irq_stat_d[`PPSP_IRQ_DONE] = 1'b1;
    end
    if (cycle_event & (req_mode == `PPSP_REQ_CYCLE)) begin
      irq_stat_d[`PPSP_IRQ_CYCLE] = 1'b1;
    end
    if (buf3_event) begin
      irq_stat_d[`PPSP_IRQ_BUF3] = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= `PPSP_RST_IRQ;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ==================================================
  // master pin activity per mode
  // pin order: 0 read pin, 1 write pin, 2 byte enable
  // read pin carries direction in master mode 1
  assign pin_act[0] = is_master1 ? (busy & ~xfer_wr_q) : (strobe & ~xfer_wr_q);
  // write pin carries enable in master mode 1
  assign pin_act[1] = is_master1 ? strobe : (strobe & xfer_wr_q);
  // byte enable spans the whole transfer
  assign pin_act[2] = busy;

  assign pin_pol = {port_control_q[`PPSP_BIT_BYTE_EN_POL],
                    port_control_q[`PPSP_BIT_WR_POL],
                    port_control_q[`PPSP_BIT_RD_POL]};

  ppsp_pol u_pol (
    .act_i      (pin_act),
    .pol_i      (pin_pol),
    .addr_sel_i (pin_func_q),
    .addr_i     (xfer_addr_q),
    .pin_o      (pin_lvl)
  );

  // ==================================================
  // pin drivers; strobe pins are inputs in slave modes unless their pin function selects an address bit
  assign read_strobe_pin_o       = pin_lvl[0];
  assign write_strobe_pin_o      = pin_lvl[1];
  assign byte_enable_pin_o       = pin_lvl[2];
  assign read_strobe_pin_oe_n_o  = ~(is_master | pin_func_q[0]);
  assign write_strobe_pin_oe_n_o = ~(is_master | pin_func_q[1]);
endmodule
`default_nettype wire

// ---- ppsp_xfer.v ----
// master transfer sequencer: setup, strobe and hold phases with busy
`timescale 1ns/1ps
`default_nettype none
`include "ppsp_defs.vh"
module ppsp_xfer (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // control
  input  wire       start_i,
  // status
  output wire       busy_o,
  output wire       strobe_o,
  output wire       done_o
);
  localparam [3:0] ST_IDLE   = 4'h1;
  localparam [3:0] ST_SETUP  = 4'h2;
  localparam [3:0] ST_STROBE = 4'h4;
  localparam [3:0] ST_HOLD   = 4'h8;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg       done_q;
  reg       done_d;

  // ==================================================
  // phase sequencing, count reloads on entry to setup, strobe and hold
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q - 4'h1;
    done_d  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cnt_d = `PPSP_SETUP_CYC;
        if (start_i) begin
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_q == 4'h1) begin
          state_d = ST_STROBE;
          cnt_d   = `PPSP_STROBE_CYC;
        end
      end
      ST_STROBE: begin
        if (cnt_q == 4'h1) begin
          state_d = ST_HOLD;
          cnt_d   = `PPSP_HOLD_CYC;
        end
      end
      ST_HOLD: begin
        if (cnt_q == 4'h1) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
    end
  end

  // busy covers every phase; drops with the done pulse
  assign busy_o   = ~state_q[0];
  assign strobe_o = state_q[2];
  assign done_o   = done_q;
endmodule
`default_nettype wire

// ---- tb_ppsp_top.sv ----
// self-checking bench for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module tb_ppsp_top;
  // ==========================================
  // bench signals
  logic        clk_i, rst_n_i, cyc, stb, we;
  logic [7:0]  adr;
  logic [31:0] wdat, q;
  wire  [31:0] dat_o;
  wire         ack, be_o, wr_o, wr_oe_n, rd_o, rd_oe_n, irq, cs, h_wr, h_rd;
  wire  [1:0]  pa;
  int          num_errors, n_tests, r;
  // wire level: whoever drives wins
  wire wr_pin = wr_oe_n ? h_wr : wr_o;
  wire rd_pin = rd_oe_n ? h_rd : rd_o;
  ppsp_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .chip_select_one_pin_i(cs), .port_address_lines_i(pa), .byte_enable_pin_o(be_o),
    .write_strobe_pin_i(wr_pin), .write_strobe_pin_o(wr_o), .write_strobe_pin_oe_n_o(wr_oe_n),
    .read_strobe_pin_i(rd_pin), .read_strobe_pin_o(rd_o), .read_strobe_pin_oe_n_o(rd_oe_n), .irq_o(irq));
  ppsp_host_model u_host (.clk_i(clk_i), .cs_o(cs), .adr_o(pa), .wr_o(h_wr), .rd_o(h_rd));
  // ==========================================
  // compare, verdict and bus cycle
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // request on an edge, held to the edge that samples ack, released there; returns at the next falling edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    q = dat_o;
    {cyc, stb} <= 2'b00;
    @(negedge clk_i);
  endtask
  // expected {byte enable, write pin, read pin} in cycle k after a start
  function automatic logic [2:0] xp(int k, logic [1:0] m, logic d, logic [2:0] p, logic [2:0] pf, logic [2:0] a);
    logic [2:0] act;
    act = {k < 5, (k == 2 || k == 3) && (m == 2'h3 || d),
           m == 2'h3 ? k < 5 && !d : (k == 2 || k == 3) && !d};
    return (pf & a) | (~pf & (act ~^ p));
  endfunction
  initial begin
    clk_i = 0;
    forever #2 clk_i = ~clk_i;
  end
  // ==========================================
  // main sequence
  initial begin
    logic [2:0] p, pf, a;
    logic [1:0] m;
    logic       d;
    {rst_n_i, cyc, stb, we, adr, wdat} = '0;
    num_errors = 0;
    n_tests = 0;
    r = $urandom(32'h16b1);
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1;
    // reset values, unmapped place, read-only busy
    for (int o = 0; o < 7; o++) begin
      wb(0, 8'(o * 4), 0);
      chk("reset reg", 0, q);
    end
    chk("idle pins", 32'h3e, {be_o, wr_o, rd_o, wr_oe_n, rd_oe_n, irq});
    wb(1, 8'h18, $urandom);
    wb(0, 8'h18, 0);
    chk("unmapped", 0, q);
    wb(1, 8'h04, 32'he300);
    wb(0, 8'h04, 0);
    chk("busy ro", 32'h6300, q & 32'he300);
    chk("master drives", 0, {wr_oe_n, rd_oe_n});
    wb(1, 8'h04, 0);
    chk("slave releases", 3, {wr_oe_n, rd_oe_n});
    $display("test reset done");
    // byte enable idle level for all eight values of control bits 2 to 0
    for (int i = 0; i < 8; i++) begin
      wb(1, 8'h00, i);
      wb(0, 8'h00, 0);
      chk("control", i, q & 7);
      chk("be idle", !i[2], be_o);
    end
    $display("test polarity done");
    // master transfers in both modes and directions, some pins as address lines
    wb(1, 8'h14, 7);
    for (int t = 0; t < 8; t++) begin
      m = 2'h2 + 2'(t[0]);
      d = t[1];
      p = 3'($urandom);
      pf = t[2] ? 3'($urandom) : 3'h0;
      a = 3'($urandom);
      wb(1, 8'h00, p);
      wb(1, 8'h0c, pf);
      wb(1, 8'h04, 32'h2000 | {m, 8'h00});
      wb(1, 8'h08, {a, 6'h0, d, 1'b1});
      fork
        for (int k = 1; k < 6; k++) begin
          chk("pins", xp(k, m, d, p, pf, a), {be_o, wr_o, rd_o});
          @(negedge clk_i);
        end
        begin
          wb(0, 8'h04, 0);
          chk("busy", 1, q[15]);
        end
      join
      wb(0, 8'h04, 0);
      chk("busy cleared", 0, q[15]);
      wb(0, 8'h10, 0);
      chk("done flag", 1, q);
      chk("irq", 1, irq);
      wb(1, 8'h10, 1);
      chk("irq clear", 0, irq);
    end
    $display("test master done");
    // legacy slave: only the fourth cycle reaches the last buffer
    p = 3'($urandom);
    wb(1, 8'h00, p);
    wb(1, 8'h0c, 0);
    wb(1, 8'h04, 32'h6000);
    u_host.set_pol(p[1], p[0]);
    for (int i = 0; i < 4; i++) begin
      wb(0, 8'h10, 0);
      chk("buffer flag", 0, q);
      u_host.cycle(i[0], 2'($urandom));
    end
    wb(0, 8'h10, 0);
    chk("buffer flag", 4, q);
    chk("irq", 1, irq);
    wb(1, 8'h14, 0);
    chk("irq masked", 0, irq);
    wb(1, 8'h10, 4);
    // enhanced slave: address lines pick the buffer
    wb(1, 8'h04, 32'h6100);
    u_host.cycle(1, 2);
    wb(0, 8'h10, 0);
    chk("buffer 2", 0, q);
    u_host.cycle(0, 3);
    wb(0, 8'h10, 0);
    chk("buffer 3", 4, q);
    wb(1, 8'h10, 4);
    wb(1, 8'h04, 32'h2000);
    u_host.cycle(1, 0);
    wb(0, 8'h10, 0);
    chk("cycle flag", 2, q);
    $display("test slave done");
    give_verdict();
  end
endmodule
`default_nettype wire
